// File: logic/iets_params.svh
// Behaviour
// - four header bytes precede configuration content
// - byte four holds version code one
// - slot count one to eight; zero disables
// - slot entries of six bytes from byte six
// - entry byte one carries two-bit data format
// - four control bytes, two bits per input
// - 00/10 off, 11 rising, 01 falling incoming
// - enabled inputs stamp both transitions
// - master writes configuration record first
// - host reads reported record on new flag
// - host clears new flag after saving
// - bad record number or unconfigured reads error
`ifndef IETS_PARAMS_SVH
`define IETS_PARAMS_SVH
`define IETS_HDR_BYTES      8'h04
`define IETS_VER_BYTE       8'h04
`define IETS_CNT_BYTE       8'h05
`define IETS_FIRST_SLOT     8'h06
`define IETS_ENTRY_BYTES    8'h06
`define IETS_VERSION        8'h01
`define IETS_MAX_SLOTS      8'h08
`define IETS_SLOT_LO        8'h04
`define IETS_SLOT_HI        8'h0b
`define IETS_REC_CFG        8'hf0
`define IETS_REC_MSG_LO     8'h64
`define IETS_REC_MSG_HI     8'h72
`define IETS_ERR_CODE       16'h80b0
`define IETS_REG_CTRL       4'h0
`define IETS_REG_STAT       4'h1
`define IETS_REG_MASK       4'h2
`define IETS_REG_REC        4'h3
`define IETS_REG_DATA       4'h4
`define IETS_REG_RESULT     4'h5
`define IETS_REG_RDATA      4'h6
`endif

// File: logic/iets_pkg.sv
package iets_pkg;
   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_WRITE = 4'b0010,
      ST_READ = 4'b0100,
      ST_DONE = 4'b1000
   } iets_host_e;
   typedef logic [1:0] iets_code_t;
endpackage

// File: logic/iets_link_if.sv
`timescale 1ns/1ps
interface iets_link_if;
   // record write: start, bytes, end
   logic       wr_start;
   logic       wr_valid;
   logic [7:0] wr_byte;
   logic       wr_end;
   logic [7:0] rec_num;
   logic       wr_ack;
   logic       wr_err;
   // record read
   logic       rd_req;
   logic       rd_ack;
   logic       rd_err;
   logic [15:0] rd_code;
   logic [7:0] rd_byte;
   // message event
   logic       msg_new;
   logic [7:0] msg_rec;
   modport dev (input wr_start, wr_valid, wr_byte, wr_end, rec_num, rd_req,
      output wr_ack, wr_err, rd_ack, rd_err, rd_code, rd_byte, msg_new,
      msg_rec);
   modport host (output wr_start, wr_valid, wr_byte, wr_end, rec_num,
      rd_req, input wr_ack, wr_err, rd_ack, rd_err, rd_code, rd_byte,
      msg_new, msg_rec);
endinterface // iets_link_if

// File: logic/iets_device.sv
`timescale 1ns/1ps
`include "iets_params.svh"
module iets_device #(
   parameter int SLOTS  = 8,
   parameter int INPUTS = 16
) (
   // clock and reset
   input  wire logic                  ref_clk,
   input  wire logic                  reset,
   // link
   iets_link_if.dev                   link,
   // message source
   input  wire logic                  msg_event,
   input  wire logic [7:0]            msg_event_rec,
   input  wire logic [7:0]            msg_data,
   // decoded configuration
   output logic                       stamp_active,
   output logic [SLOTS-1:0][7:0]      slot_number,
   output logic [SLOTS-1:0][1:0]      value_status_format,
   output logic [SLOTS-1:0][7:0]      input_count,
   output logic [SLOTS-1:0][INPUTS-1:0] input_stamp_enable,
   output logic [SLOTS-1:0][INPUTS-1:0] input_incoming_transition_select
);
   typedef struct packed {
      logic [7:0]                      idx;
      logic                            bad;
      logic [7:0]                      cnt;
      logic [SLOTS-1:0][7:0]           sn;
      logic [SLOTS-1:0][1:0]           df;
      logic [SLOTS-1:0][7:0]           ic;
      logic [SLOTS-1:0][INPUTS-1:0]    en;
      logic [SLOTS-1:0][INPUTS-1:0]    rise;
      logic                            act;
      logic                            cfgd;
      logic [SLOTS-1:0][7:0]           sn_c;
      logic [SLOTS-1:0][1:0]           df_c;
      logic [SLOTS-1:0][7:0]           ic_c;
      logic [SLOTS-1:0][INPUTS-1:0]    en_c;
      logic [SLOTS-1:0][INPUTS-1:0]    rise_c;
      logic                            wr_ack;
      logic                            wr_err;
      logic                            rd_ack;
      logic                            rd_err;
      logic [15:0]                     rd_code;
      logic [7:0]                      rd_byte;
      logic                            msg_new;
      logic [7:0]                      msg_rec;
   } iets_dev_s;
   iets_dev_s s_r;
   iets_dev_s s_nxt;
   logic [7:0] off;
   logic [7:0] ent;
   logic [7:0] pos;
   always_comb
   begin
      s_nxt = s_r;
      s_nxt.wr_ack = 1'b0;
      s_nxt.wr_err = 1'b0;
      s_nxt.rd_ack = 1'b0;
      s_nxt.rd_err = 1'b0;
      s_nxt.msg_new = 1'b0;
      off = s_r.idx - `IETS_FIRST_SLOT;
      ent = off / `IETS_ENTRY_BYTES;
      pos = off % `IETS_ENTRY_BYTES;
      if (link.wr_start)
      begin
         s_nxt.idx = 8'h00;
         s_nxt.bad = (link.rec_num != `IETS_REC_CFG);
         s_nxt.cnt = 8'h00;
         s_nxt.en = '0;
         s_nxt.rise = '0;
         s_nxt.sn = '0;
         s_nxt.df = '0;
         s_nxt.ic = '0;
      end
      else if (link.wr_valid)
      begin
         s_nxt.idx = s_r.idx + 8'h01;
         if (s_r.idx < `IETS_HDR_BYTES)
            s_nxt.bad = s_r.bad;
         else if (s_r.idx == `IETS_VER_BYTE)
         begin
            if (link.wr_byte[3:0] != 4'(`IETS_VERSION))
               s_nxt.bad = 1'b1;
         end
         else if (s_r.idx == `IETS_CNT_BYTE)
         begin
            s_nxt.cnt = {4'h0, link.wr_byte[3:0]};
            if (link.wr_byte[3:0] > 4'(`IETS_MAX_SLOTS))
               s_nxt.bad = 1'b1;
         end
         else if (ent < s_r.cnt && ent < 8'(SLOTS))
         begin
            unique case (pos)
               8'h00:
               begin
                  s_nxt.sn[ent[2:0]] = link.wr_byte;
                  if (link.wr_byte < `IETS_SLOT_LO ||
                      link.wr_byte > `IETS_SLOT_HI)
                     s_nxt.bad = 1'b1;
               end
               8'h01:
               begin
                  s_nxt.df[ent[2:0]] = link.wr_byte[7:6];
                  s_nxt.ic[ent[2:0]] = {2'h0, link.wr_byte[5:0]};
                  if (link.wr_byte[7])
                     s_nxt.bad = 1'b1;
               end
               default:
               begin
                  for (int i = 0; i < 4; i++)
                  begin
                     s_nxt.en[ent[2:0]][(pos - 8'h02) * 4 + i] =
                        link.wr_byte[2*i] ;
                     s_nxt.rise[ent[2:0]][(pos - 8'h02) * 4 + i] =
                        link.wr_byte[2*i+1];
                  end
               end
            endcase
         end
      end
      if (link.wr_end)
      begin
         s_nxt.wr_ack = 1'b1;
         if (s_r.bad || s_r.idx < `IETS_FIRST_SLOT ||
             s_r.idx < `IETS_FIRST_SLOT + s_r.cnt * `IETS_ENTRY_BYTES)
         begin
            if (!(s_r.cnt == 8'h00 && !s_r.bad &&
                  s_r.idx >= `IETS_FIRST_SLOT))
               s_nxt.wr_err = 1'b1;
         end
         if (!s_nxt.wr_err)
         begin
            s_nxt.cfgd = 1'b1;
            s_nxt.act = (s_r.cnt != 8'h00);
            s_nxt.sn_c = s_r.sn;
            s_nxt.df_c = s_r.df;
            s_nxt.ic_c = s_r.ic;
            s_nxt.en_c = s_r.en;
            s_nxt.rise_c = s_r.rise;
         end
      end
      if (link.rd_req)
      begin
         s_nxt.rd_ack = 1'b1;
         s_nxt.rd_byte = msg_data;
         s_nxt.rd_code = 16'h0000;
         if (!s_r.cfgd || link.rec_num < `IETS_REC_MSG_LO ||
             link.rec_num > `IETS_REC_MSG_HI)
         begin
            s_nxt.rd_err = 1'b1;
            s_nxt.rd_code = `IETS_ERR_CODE;
         end
      end
      if (msg_event && s_r.act)
      begin
         s_nxt.msg_new = 1'b1;
         s_nxt.msg_rec = msg_event_rec;
      end
   end
   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
         s_r <= '0;
      else
         s_r <= s_nxt;
   end
   assign link.wr_ack = s_r.wr_ack;
   assign link.wr_err = s_r.wr_err;
   assign link.rd_ack = s_r.rd_ack;
   assign link.rd_err = s_r.rd_err;
   assign link.rd_code = s_r.rd_code;
   assign link.rd_byte = s_r.rd_byte;
   assign link.msg_new = s_r.msg_new;
   assign link.msg_rec = s_r.msg_rec;
   assign stamp_active = s_r.act;
   assign slot_number = s_r.sn_c;
   assign value_status_format = s_r.df_c;
   assign input_count = s_r.ic_c;
   assign input_stamp_enable = s_r.en_c;
   assign input_incoming_transition_select = s_r.rise_c;
endmodule // iets_device

// File: logic/iets_host.sv
`timescale 1ns/1ps
`include "iets_params.svh"
module iets_host (
   // clock and reset
   input  wire logic        ref_clk,
   input  wire logic        reset,
   // link
   iets_link_if.host        link,
   // software port
   input  wire logic [3:0]  addr,
   input  wire logic [7:0]  wdata,
   input  wire logic        wr,
   input  wire logic        rd,
   output logic [31:0]      rdata,
   output logic             irq
);
   typedef struct packed {
      iets_pkg::iets_host_e st;
      logic                 wr_start;
      logic                 wr_valid;
      logic [7:0]           wr_byte;
      logic                 wr_end;
      logic [7:0]           rec_num;
      logic                 rd_req;
      logic                 new_flag;
      logic [7:0]           new_rec;
      logic [2:0]           stat;
      logic [2:0]           mask;
      logic [15:0]          result;
      logic [7:0]           rbyte;
      logic [31:0]          rdata;
      logic                 irq;
   } iets_host_s;
   iets_host_s h_r;
   iets_host_s h_nxt;
   always_comb
   begin
      h_nxt = h_r;
      h_nxt.wr_start = 1'b0;
      h_nxt.wr_valid = 1'b0;
      h_nxt.wr_end = 1'b0;
      h_nxt.rd_req = 1'b0;
      h_nxt.rdata = 32'h0000_0000;
      if (rd)
      begin
         unique case (addr)
            `IETS_REG_CTRL: h_nxt.rdata = {31'h0, h_r.new_flag};
            `IETS_REG_STAT:
            begin
               h_nxt.rdata = {29'h0, h_r.stat};
               h_nxt.stat = 3'h0;
            end
            `IETS_REG_MASK: h_nxt.rdata = {29'h0, h_r.mask};
            `IETS_REG_REC: h_nxt.rdata = {24'h0, h_r.new_rec};
            `IETS_REG_RESULT: h_nxt.rdata = {16'h0, h_r.result};
            `IETS_REG_RDATA: h_nxt.rdata = {24'h0, h_r.rbyte};
            default: h_nxt.rdata = 32'h0000_0000;
         endcase
      end
      if (wr)
      begin
         unique case (addr)
            `IETS_REG_CTRL:
            begin
               if (wdata[0] && h_r.st == iets_pkg::ST_IDLE)
               begin
                  h_nxt.wr_start = 1'b1;
               end
               if (wdata[1])
                  h_nxt.wr_end = 1'b1;
               if (wdata[2])
               begin
                  h_nxt.rd_req = 1'b1;
                  h_nxt.st = iets_pkg::ST_READ;
                  if (h_r.new_flag)
                     h_nxt.rec_num = h_r.new_rec;
               end
               if (wdata[3] && h_r.st == iets_pkg::ST_DONE)
               begin
                  h_nxt.new_flag = 1'b0;
                  h_nxt.st = iets_pkg::ST_IDLE;
               end
            end
            `IETS_REG_MASK: h_nxt.mask = wdata[2:0];
            `IETS_REG_REC: h_nxt.rec_num = wdata;
            `IETS_REG_DATA:
            begin
               h_nxt.wr_valid = 1'b1;
               h_nxt.wr_byte = wdata;
            end
            default: h_nxt.mask = h_r.mask;
         endcase
      end
      if (link.wr_ack)
      begin
         h_nxt.stat[0] = 1'b1;
         h_nxt.result = link.wr_err ? 16'h0001 : 16'h0000;
      end
      if (link.rd_ack && h_r.st == iets_pkg::ST_READ)
      begin
         h_nxt.stat[1] = 1'b1;
         h_nxt.result = link.rd_code;
         h_nxt.rbyte = link.rd_byte;
         // plain reads go straight back to idle
         h_nxt.st = h_r.new_flag ? iets_pkg::ST_DONE : iets_pkg::ST_IDLE;
      end
      if (link.msg_new && h_r.st == iets_pkg::ST_IDLE)
      begin
         h_nxt.stat[2] = 1'b1;
         h_nxt.new_flag = 1'b1;
         h_nxt.new_rec = link.msg_rec;
      end
      h_nxt.irq = |(h_nxt.stat & h_nxt.mask);
   end
   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         h_r <= '0;
         h_r.st <= iets_pkg::ST_IDLE;
      end
      else
         h_r <= h_nxt;
   end
   assign link.wr_start = h_r.wr_start;
   assign link.wr_valid = h_r.wr_valid;
   assign link.wr_byte = h_r.wr_byte;
   assign link.wr_end = h_r.wr_end;
   assign link.rec_num = h_r.rec_num;
   assign link.rd_req = h_r.rd_req;
   assign rdata = h_r.rdata;
   assign irq = h_r.irq;
endmodule // iets_host

// File: verification/iets_assertions.sv
`timescale 1ns/1ps
module iets_assertions (
   // clock and reset
   input wire logic        ref_clk,
   input wire logic        reset,
   // record write
   input wire logic        wr_end,
   input wire logic [7:0]  rec_num,
   input wire logic        wr_ack,
   input wire logic        wr_err,
   // record read
   input wire logic        rd_req,
   input wire logic        rd_ack,
   input wire logic        rd_err,
   input wire logic [15:0] rd_code
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (reset);
   // write closed with refusal
   sequence s_wr_refused;
      wr_end ##1 (wr_ack && wr_err);
   endsequence
   // read answered with error code
   sequence s_rd_refused;
      rd_req ##1 (rd_ack && rd_err && rd_code == 16'h80b0);
   endsequence
   AST_WR_ACK: assert property (wr_end |=> wr_ack)
      else $error("no write ack after end");
   AST_WR_ACK_CAUSE: assert property (wr_ack |-> $past(wr_end))
      else $error("write ack without end");
   AST_WR_ERR_ACK: assert property (wr_err |-> wr_ack)
      else $error("write error outside ack");
   AST_WR_BAD_REC: assert property (
      wr_end && rec_num != 8'hf0 |-> s_wr_refused)
      else $error("wrong record number accepted");
   AST_RD_ACK: assert property (rd_req |=> rd_ack)
      else $error("no read ack");
   AST_RD_CAUSE: assert property (rd_ack |-> $past(rd_req))
      else $error("read ack without request");
   AST_RD_RANGE: assert property (
      rd_req && (rec_num < 8'h64 || rec_num > 8'h72) |-> s_rd_refused)
      else $error("out of range read not refused");
   AST_RD_CODE: assert property (
      rd_ack && rd_err |-> rd_code == 16'h80b0)
      else $error("wrong read error code");
endmodule // iets_assertions

// File: verification/testbench.sv
`timescale 1ns/1ps
module testbench;
   logic             ref_clk, reset, wr, rd, irq, act, msg_event;
   logic             w_ack, w_err, r_ack, r_err;
   logic [3:0]       addr;
   logic [7:0]       wdata, msg_event_rec, msg_data, m_rec;
   logic [15:0]      r_code;
   logic [31:0]      rdata;
   logic [7:0][7:0]  slot, icnt;
   logic [7:0][1:0]  fmt;
   logic [7:0][15:0] en, inc;
   logic [7:0]       rec [0:53];
   logic [7:0]       e_slot [0:7];
   logic [1:0]       e_fmt [0:7];
   logic [31:0]      e_ctl [0:7];
   int               e_n, n_mismatch, n_tests;
   int               cyc = 0;
   iets_link_if link ();
   iets_device iets_device_inst (.ref_clk(ref_clk), .reset(reset),
      .link(link), .msg_event(msg_event), .msg_event_rec(msg_event_rec),
      .msg_data(msg_data), .stamp_active(act), .slot_number(slot),
      .value_status_format(fmt), .input_count(icnt),
      .input_stamp_enable(en), .input_incoming_transition_select(inc));
   iets_host iets_host_inst (.ref_clk(ref_clk), .reset(reset),
      .link(link), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .irq(irq));
   iets_assertions iets_assertions_inst (.ref_clk(ref_clk),
      .reset(reset), .wr_end(link.wr_end), .rec_num(link.rec_num),
      .wr_ack(link.wr_ack), .wr_err(link.wr_err), .rd_req(link.rd_req),
      .rd_ack(link.rd_ack), .rd_err(link.rd_err), .rd_code(link.rd_code));
   initial
   begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   // latch link answers, cut a hang short
   always @(posedge ref_clk)
   begin
      cyc <= cyc + 1;
      if (link.wr_ack)
      begin
         w_ack <= 1'b1;
         w_err <= link.wr_err;
      end
      if (link.rd_ack)
      begin
         r_ack <= 1'b1;
         r_err <= link.rd_err;
         r_code <= link.rd_code;
      end
      if (link.msg_new)
         m_rec <= link.msg_rec;
      if (cyc == 20000)
      begin
         n_mismatch++;
         stop_test();
      end
   end
   task automatic stop_test();
      if (n_mismatch == 0 && n_tests > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(string nm, logic [31:0] e, logic [31:0] s);
      n_tests++;
      if (e !== s)
      begin
         n_mismatch++;
         $display("ERROR %s exp %h got %h", nm, e, s);
      end
   endtask
   task automatic wreg(logic [3:0] a, logic [7:0] d);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge ref_clk);
      wr <= 1'b0;
      @(posedge ref_clk);
      #1;
   endtask
   task automatic rreg(logic [3:0] a, output logic [31:0] d);
      addr <= a;
      rd <= 1'b1;
      @(posedge ref_clk);
      rd <= 1'b0;
      #1 d = rdata;
      @(posedge ref_clk);
      #1;
   endtask
   // per-input enable, or rising incoming when rise is set
   function automatic logic [15:0] pick(logic [31:0] c, bit rise);
      for (int i = 0; i < 16; i++)
         pick[i] = c[2*i] & (c[2*i+1] | !rise);
   endfunction
   task automatic build(int ns, bit upd);
      logic [7:0]  s;
      logic [1:0]  f;
      logic [31:0] c;
      for (int i = 0; i < 4; i++)
         rec[i] = 8'($urandom);
      rec[4] = 8'h01;
      rec[5] = 8'(ns);
      for (int k = 0; k < ns; k++)
      begin
         s = 8'h04 + 8'($urandom % 8);
         f = 2'($urandom % 2);
         c = (ns == 8) ? 32'hb1b1b1b1 : $urandom;
         rec[6+6*k] = s;
         rec[7+6*k] = {f, 6'h10};
         for (int b = 0; b < 4; b++)
            rec[8+6*k+b] = c[8*b +: 8];
         if (upd)
         begin
            e_slot[k] = s;
            e_fmt[k] = f;
            e_ctl[k] = c;
         end
      end
      if (upd)
         e_n = ns;
   endtask
   task automatic send(logic [7:0] rn, int nb, logic e);
      wreg(4'h3, rn);
      wreg(4'h0, 8'h01);
      for (int i = 0; i < nb; i++)
         wreg(4'h4, rec[i]);
      w_ack <= 1'b0;
      wreg(4'h0, 8'h02);
      repeat (2) @(posedge ref_clk);
      #1;
      chk("wr ack", 1, w_ack);
      chk("wr err", e, w_err);
      chk("act", e_n != 0, act);
      for (int k = 0; k < e_n; k++)
      begin
         chk("slot", e_slot[k], slot[k]);
         chk("fmt", e_fmt[k], fmt[k]);
         chk("cnt", 8'h10, icnt[k]);
         chk("en", pick(e_ctl[k], 0), en[k]);
         chk("inc", pick(e_ctl[k], 1), inc[k] & en[k]);
      end
   endtask
   task automatic host_record_read_block(logic [7:0] rn, logic e);
      r_ack <= 1'b0;
      wreg(4'h3, rn);
      wreg(4'h0, 8'h04);
      repeat (2) @(posedge ref_clk);
      #1;
      chk("rd ack", 1, r_ack);
      chk("rd err", e, r_err);
      if (e)
         chk("rd code", 16'h80b0, r_code);
   endtask
   initial
   begin
      logic [31:0] d;
      logic [7:0]  v;
      int          n;
      reset = 1'b1;
      {msg_event, msg_event_rec, msg_data} = 17'h00000;
      {addr, wdata, wr, rd} = 14'h0000;
      {n_mismatch, n_tests, e_n} = 96'h0;
      void'($urandom(77));
      repeat (6) @(posedge ref_clk);
      reset <= 1'b0;
      @(posedge ref_clk);
      #1;
      host_record_read_block(8'h64, 1'b1);
      for (int t = 0; t < 4; t++)
      begin
         n = (t == 0) ? 8 : 1 + $urandom % 8;
         build(n, 1'b1);
         send(8'hf0, 6 + 6 * n, 1'b0);
      end
      chk("irq", 0, irq);
      wreg(4'h2, 8'h01);
      chk("irq", 1, irq);
      rreg(4'h1, d);
      chk("stat", 1, d[0]);
      chk("irq", 0, irq);
      // refused records: version, count, slot, format, number, length
      for (int k = 0; k < 8; k++)
      begin
         n = 1 + $urandom % 8;
         build(n, 1'b0);
         case (k)
            0: rec[4] = 8'h02;
            1: rec[5] = 8'h09;
            2: rec[6] = 8'h03;
            3: rec[6] = 8'h0c;
            4: rec[7] = 8'h90;
            5: rec[7] = 8'hd0;
            default: ;
         endcase
         send((k == 6) ? 8'h64 : 8'hf0, 5 + 6 * n + (k != 7), 1'b1);
      end
      rreg(4'h5, d);
      chk("result", 1, d);
      host_record_read_block(8'h63, 1'b1);
      host_record_read_block(8'h73, 1'b1);
      host_record_read_block(8'h72, 1'b0);
      wreg(4'h2, 8'h04);
      v = 8'h64 + 8'($urandom % 15);
      msg_event_rec <= v;
      msg_data <= 8'($urandom);
      msg_event <= 1'b1;
      @(posedge ref_clk);
      msg_event <= 1'b0;
      repeat (3) @(posedge ref_clk);
      #1;
      chk("mrec", v, m_rec);
      chk("irq", 1, irq);
      rreg(4'h1, d);
      chk("stat", 1, d[2]);
      rreg(4'h0, d);
      chk("new", 1, d[0]);
      host_record_read_block(v, 1'b0);
      rreg(4'h5, d);
      chk("result", 0, d);
      rreg(4'h6, d);
      chk("rbyte", msg_data, d);
      wreg(4'h0, 8'h08);
      rreg(4'h0, d);
      chk("new", 0, d[0]);
      build(0, 1'b1);
      send(8'hf0, 6, 1'b0);
      stop_test();
   end
endmodule // testbench
